//--- core/dac_ctl_top.sv
// Operation
// - Reference starts external after power-up until software enables internal.
// - Wide variant: bit 12 picks reference level, bit 10 selects internal.
// - Narrow variant: bit 8 selects the internal reference.
// - Power-on reset spans 10 ms brownout and loads calibration data.
// - Monitor mux routes one addressed channel to the monitor output.
// - Nothing is routed to the monitor output until monitor is enabled.
// - Monitor selection 63 puts the monitor output in high impedance.
// - Monitor mux can also route either auxiliary monitor input.
// - Register select 00 with address 1100 decodes as control write.
// - Wide variant: bits 3 and 2 enable toggle per eight-channel group.
// - Narrow variant: bits 1 and 0 enable toggle per group.
// - Every channel holds an A and a B input data register.
// - B register writes land only while its group toggle is enabled.
// - In toggle mode each strobe alternates the source between A and B.
// - First strobe after toggle set-up copies A into the DAC register.
// - After toggle is disabled the next strobe updates outputs from A.
// - Thermal enable is bit 8 on wide, bit 6 on narrow variant.
// - Enabled thermal monitor powers all amplifiers down on over-temperature.
// - Amplifiers return on soft power-up when cool, or thermal disable.
// - Each channel holds its own offset and gain register.
// - Strobe falling refills a DAC register only if written since last or toggle was just disabled, or on every strobe while its group toggles.
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module dac_ctl_top #(
  parameter int unsigned POR_CYCLES = dac_ctl_pkg::POR_CYCLES
) (
  input  wire logic        CLOCK_IN,
  input  wire logic        RST_B_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [7:0]  PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  input  wire logic        LOAD_STROBE_N_IN,
  input  wire logic        OVERTEMP_IN,
  input  wire logic        VARIANT_12B_IN,
  output dac_ctl_pkg::code_arr_t DAC_CODE_OUT,
  output logic             REF_INTERNAL_OUT,
  output logic             REF_LEVEL_HI_OUT,
  output logic             AMP_POWER_EN_OUT,
  output logic             THERMAL_SHUTDOWN_OUT,
  output logic      [5:0]  MON_ROUTE_OUT,
  output logic             MON_OE_OUT,
  output logic             BUSY_OUT
);

  dac_ctl_pkg::st_t       st_ff;
  dac_ctl_pkg::st_t       nxt_st;
  dac_ctl_pkg::code_arr_t corr;
  dac_ctl_pkg::code_arr_t src;
  logic [1:0]  tog;
  logic        v12;
  logic        therm_en;
  logic        mon_en;
  logic        ld_ev;
  logic        ot;
  logic        setup;
  logic        wr;
  logic        hit;
  logic [31:0] rd_val;
  logic [1:0]  rs;
  logic [5:0]  cadr;
  logic        pwrup;
  logic        pwrup_tk;

  // ----------------------------------------------------------------
  // Variant decode of the control word
  // ----------------------------------------------------------------
  assign v12      = st_ff.var_sync[1];
  assign therm_en = v12 ? st_ff.ctrl[dac_ctl_pkg::B12_THERM]
                        : st_ff.ctrl[dac_ctl_pkg::B14_THERM];
  assign tog      = v12 ? {st_ff.ctrl[dac_ctl_pkg::B12_TOG_HI],
                           st_ff.ctrl[dac_ctl_pkg::B12_TOG_LO]}
                        : {st_ff.ctrl[dac_ctl_pkg::B14_TOG_HI],
                           st_ff.ctrl[dac_ctl_pkg::B14_TOG_LO]};
  assign mon_en   = st_ff.ctrl[dac_ctl_pkg::MON_EN_BIT];
  assign ot       = st_ff.ot_sync[1];

  // Reference outputs; ctrl resets to zero so the external path is used
  assign REF_INTERNAL_OUT = v12 ? st_ff.ctrl[dac_ctl_pkg::B12_REF_INT]
                                : st_ff.ctrl[dac_ctl_pkg::B14_REF_INT];
  assign REF_LEVEL_HI_OUT = v12 ? st_ff.ctrl[dac_ctl_pkg::B12_REF_LVL]
                                : st_ff.ctrl[dac_ctl_pkg::B14_REF_LVL];

  // ----------------------------------------------------------------
  // Monitor mux
  // ----------------------------------------------------------------
  assign MON_ROUTE_OUT = st_ff.mon_sel;
  assign MON_OE_OUT    = mon_en
                       && (st_ff.mon_sel != dac_ctl_pkg::MON_HIZ)
                       && ((st_ff.mon_sel < 6'(dac_ctl_pkg::NCH))
                        || (st_ff.mon_sel == dac_ctl_pkg::MON_AUX_A)
                        || (st_ff.mon_sel == dac_ctl_pkg::MON_AUX_B));

  // ----------------------------------------------------------------
  // Status and data outputs
  // ----------------------------------------------------------------
  assign AMP_POWER_EN_OUT     = !st_ff.shut && !st_ff.busy;
  assign THERMAL_SHUTDOWN_OUT = st_ff.shut;
  assign BUSY_OUT             = st_ff.busy;
  assign DAC_CODE_OUT         = st_ff.dac;

  // ----------------------------------------------------------------
  // APB slave, no wait states; read data captured in setup
  // ----------------------------------------------------------------
  assign PREADY_OUT  = PSEL_IN && PENABLE_IN;
  assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && st_ff.err;
  assign PRDATA_OUT  = st_ff.rdata;
  assign setup       = PSEL_IN && !PENABLE_IN;
  assign wr          = PSEL_IN && PENABLE_IN && PWRITE_IN && !st_ff.err;
  assign rs          = PWDATA_IN[dac_ctl_pkg::CMD_RS_HI:dac_ctl_pkg::CMD_RS_LO];
  assign cadr        = PWDATA_IN[dac_ctl_pkg::CMD_ADR_HI:dac_ctl_pkg::CMD_ADR_LO];
  assign pwrup_tk    = wr && (PADDR_IN == dac_ctl_pkg::ADDR_ACT);
  assign pwrup       = pwrup_tk && PWDATA_IN[dac_ctl_pkg::ACT_PWRUP];

  // Read mux; also marks mapped addresses
  always_comb begin
    hit    = 1'b1;
    rd_val = 32'h00000000;
    if (PADDR_IN[7:6] == dac_ctl_pkg::ADDR_DAC_HI && PADDR_IN[1:0] == 2'h0) begin
      rd_val = 32'(st_ff.dac[PADDR_IN[5:2]]);
    end else begin
      case (PADDR_IN)
        dac_ctl_pkg::ADDR_CTRL: rd_val = 32'(st_ff.ctrl);
        dac_ctl_pkg::ADDR_CMD:  rd_val = 32'h00000000;
        dac_ctl_pkg::ADDR_MON:  rd_val = 32'(st_ff.mon_sel);
        dac_ctl_pkg::ADDR_ACT:  rd_val = 32'h00000000;
        dac_ctl_pkg::ADDR_STAT: rd_val = {27'h0000000, v12, REF_INTERNAL_OUT,
                                          st_ff.busy, AMP_POWER_EN_OUT, st_ff.shut};
        default: hit = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Per-channel source select and calibration
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < dac_ctl_pkg::NCH; gi++) begin : g_ch
      // B only feeds the DAC while its group toggles and B is due
      assign src[gi] = (tog[gi / 8] && st_ff.sel_b[gi]) ? st_ff.b[gi]
                                                         : st_ff.a[gi];
      dac_cal_corr u_cal (
        .data_in   (src[gi]),
        .gain_in   (st_ff.gain[gi]),
        .offset_in (st_ff.off[gi]),
        .code_out  (corr[gi])
      );
    end
  endgenerate

  // Strobe falls; ignored while the reset sequence runs
  assign ld_ev = st_ff.ld_prev && !st_ff.ld_sync[1] && !st_ff.busy;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st          = st_ff;
    nxt_st.ld_sync  = {st_ff.ld_sync[0], LOAD_STROBE_N_IN};
    nxt_st.ot_sync  = {st_ff.ot_sync[0], OVERTEMP_IN};
    nxt_st.var_sync = {st_ff.var_sync[0], VARIANT_12B_IN};
    nxt_st.ld_prev  = st_ff.ld_sync[1];
    nxt_st.tog_prev = tog;

    // Brownout interval, then calibration load
    if (st_ff.busy) begin
      if (st_ff.por_cnt == 21'(POR_CYCLES - 1)) begin
        nxt_st.busy = 1'b0;
        for (int c = 0; c < dac_ctl_pkg::NCH; c++) begin
          nxt_st.gain[c] = dac_ctl_pkg::GAIN_CAL;
          nxt_st.off[c]  = dac_ctl_pkg::OFF_CAL;
        end
      end else begin
        nxt_st.por_cnt = st_ff.por_cnt + 21'h000001;
      end
    end

    // Strobe load first so a same-cycle write re-marks the channel
    for (int c = 0; c < dac_ctl_pkg::NCH; c++) begin
      if (ld_ev && tog[c / 8]) begin
        nxt_st.dac[c]   = corr[c];
        nxt_st.sel_b[c] = !st_ff.sel_b[c];
        nxt_st.dirty[c] = 1'b0;
      end else if (ld_ev && st_ff.dirty[c]) begin
        nxt_st.dac[c]   = corr[c];
        nxt_st.dirty[c] = 1'b0;
      end
      if (tog[c / 8] && !st_ff.tog_prev[c / 8]) begin
        nxt_st.sel_b[c] = 1'b0;
      end
      if (!tog[c / 8] && st_ff.tog_prev[c / 8]) begin
        nxt_st.dirty[c] = 1'b1;
        nxt_st.sel_b[c] = 1'b0;
      end
    end

    // Setup phase answers: read data and error flag
    if (setup) begin
      nxt_st.rdata = rd_val;
      nxt_st.err   = !hit || (PWRITE_IN && st_ff.busy);
    end

    // Register writes
    if (wr) begin
      case (PADDR_IN)
        dac_ctl_pkg::ADDR_CTRL: nxt_st.ctrl    = PWDATA_IN[13:0];
        dac_ctl_pkg::ADDR_MON:  nxt_st.mon_sel = PWDATA_IN[5:0];
        dac_ctl_pkg::ADDR_CMD: begin
          if (rs == dac_ctl_pkg::RS_SFR && cadr[3:0] == dac_ctl_pkg::SFR_CTRL) begin
            nxt_st.ctrl = PWDATA_IN[13:0];
          end else if (rs != dac_ctl_pkg::RS_SFR && cadr < 6'(dac_ctl_pkg::NCH)) begin
            case (rs)
              dac_ctl_pkg::RS_DATA: begin
                if (!PWDATA_IN[dac_ctl_pkg::CMD_BSEL]) begin
                  nxt_st.a[cadr[3:0]]     = PWDATA_IN[13:0];
                  nxt_st.dirty[cadr[3:0]] = 1'b1;
                end else if (tog[cadr[3]]) begin
                  nxt_st.b[cadr[3:0]]     = PWDATA_IN[13:0];
                end
              end
              dac_ctl_pkg::RS_OFF:  nxt_st.off[cadr[3:0]]  = PWDATA_IN[13:0];
              dac_ctl_pkg::RS_GAIN: nxt_st.gain[cadr[3:0]] = PWDATA_IN[13:0];
              default: nxt_st.dirty = st_ff.dirty;
            endcase
          end
        end
        default: nxt_st.err = 1'b0;
      endcase
    end

    // Thermal latch; a fresh over-temperature beats a power-up clear
    if (!therm_en) begin
      nxt_st.shut = 1'b0;
    end else if (ot) begin
      nxt_st.shut = 1'b1;
    end else if (pwrup) begin
      nxt_st.shut = 1'b0;
    end

    // Soft reset restarts the whole sequence
    if (pwrup_tk && PWDATA_IN[dac_ctl_pkg::ACT_RESET]) begin
      nxt_st.busy    = 1'b1;
      nxt_st.por_cnt = 21'h000000;
      nxt_st.ctrl    = dac_ctl_pkg::CTRL_RST;
      nxt_st.mon_sel = 6'h00;
      nxt_st.dirty   = '0;
      nxt_st.sel_b   = '0;
      nxt_st.shut    = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      st_ff <= dac_ctl_pkg::ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RST_B_IN);

  sequence s_tog_load;
    ld_ev && tog[0];
  endsequence

  sequence s_plain_idle;
    ld_ev && !tog[1] && !st_ff.dirty[12];
  endsequence

  a_ref_select: assert property (
    (wr && PADDR_IN == dac_ctl_pkg::ADDR_CTRL && !v12 && PWDATA_IN[10])
    |=> REF_INTERNAL_OUT)
    else $error("internal reference not selected after control write");

  a_mon_gated: assert property (!mon_en |-> !MON_OE_OUT)
    else $error("monitor output driven while monitor disabled");

  a_mon_hiz: assert property (
    (st_ff.mon_sel == dac_ctl_pkg::MON_HIZ) |-> !MON_OE_OUT)
    else $error("monitor output driven at selection 63");

  a_b_guard: assert property (!tog[0] |=> $stable(st_ff.b[7:0]))
    else $error("B register changed with toggle disabled");

  a_tog_alt: assert property (
    s_tog_load |=> (st_ff.sel_b[0] != $past(st_ff.sel_b[0]))
                   && (st_ff.dac[0] == $past(corr[0])))
    else $error("toggle strobe did not alternate source");

  a_tog_clear: assert property ($rose(tog[0]) |=> !st_ff.sel_b[0])
    else $error("A/B selection not cleared on toggle enable");

  a_dirty_gate: assert property (
    s_plain_idle ##1 !ld_ev |-> $stable(st_ff.dac[12]))
    else $error("DAC register reloaded without a new write");

  a_therm_down: assert property (
    (therm_en && ot && !(pwrup_tk && PWDATA_IN[1]))
    |=> !AMP_POWER_EN_OUT ##1 (!AMP_POWER_EN_OUT || !$past(therm_en)
                               || ($past(pwrup) && !$past(ot))))
    else $error("amplifiers not powered down on over-temperature");

  a_therm_hold: assert property (
    (st_ff.shut && therm_en && !pwrup_tk) |=> st_ff.shut)
    else $error("thermal shutdown flag dropped without a clear");

  a_ctrl_decode: assert property (
    (wr && PADDR_IN == dac_ctl_pkg::ADDR_CMD && rs == dac_ctl_pkg::RS_SFR
     && cadr[3:0] == dac_ctl_pkg::SFR_CTRL) |=> (st_ff.ctrl == $past(PWDATA_IN[13:0])))
    else $error("special control write not decoded");

  a_therm_off: assert property (!therm_en |=> !st_ff.shut)
    else $error("shutdown flag held with thermal monitor off");

  a_cal_load: assert property (
    $fell(st_ff.busy) |-> (st_ff.gain[0] == dac_ctl_pkg::GAIN_CAL)
                          && (st_ff.off[0] == dac_ctl_pkg::OFF_CAL))
    else $error("calibration not loaded after reset sequence");

  a_tog_off: assert property (
    ($fell(tog[0]) && !pwrup_tk) |=> st_ff.dirty[0] && !st_ff.sel_b[0])
    else $error("toggle disable did not mark A for reload");

endmodule : dac_ctl_top

`default_nettype wire

//--- core/dac_ctl_pkg.sv
package dac_ctl_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NCH = 16;
  localparam int DW  = 14;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CMD  = 8'h04;
  localparam logic [7:0] ADDR_MON  = 8'h08;
  localparam logic [7:0] ADDR_ACT  = 8'h0c;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  localparam logic [1:0] ADDR_DAC_HI = 2'h1;

  // ----------------------------------------------------------------
  // Control word bit positions, wide and narrow variants
  // ----------------------------------------------------------------
  localparam int B14_REF_LVL = 12;
  localparam int B14_REF_INT = 10;
  localparam int B14_THERM   = 8;
  localparam int B14_TOG_HI  = 3;
  localparam int B14_TOG_LO  = 2;
  localparam int B12_REF_LVL = 10;
  localparam int B12_REF_INT = 8;
  localparam int B12_THERM   = 6;
  localparam int B12_TOG_HI  = 1;
  localparam int B12_TOG_LO  = 0;
  localparam int MON_EN_BIT  = 11;

  // ----------------------------------------------------------------
  // Command word fields and decode values
  // ----------------------------------------------------------------
  localparam int CMD_BSEL   = 24;
  localparam int CMD_RS_HI  = 23;
  localparam int CMD_RS_LO  = 22;
  localparam int CMD_ADR_HI = 21;
  localparam int CMD_ADR_LO = 16;
  localparam logic [1:0] RS_DATA = 2'h3;
  localparam logic [1:0] RS_OFF  = 2'h2;
  localparam logic [1:0] RS_GAIN = 2'h1;
  localparam logic [1:0] RS_SFR  = 2'h0;
  localparam logic [3:0] SFR_CTRL = 4'hc;
  localparam int ACT_PWRUP = 0;
  localparam int ACT_RESET = 1;

  // ----------------------------------------------------------------
  // Monitor selections
  // ----------------------------------------------------------------
  localparam logic [5:0] MON_AUX_A = 6'h10;
  localparam logic [5:0] MON_AUX_B = 6'h11;
  localparam logic [5:0] MON_HIZ   = 6'h3f;

  // ----------------------------------------------------------------
  // Reset and calibration values, timing
  // ----------------------------------------------------------------
  localparam logic [DW-1:0] CTRL_RST = 14'h0000;
  localparam logic [DW-1:0] GAIN_CAL = 14'h3fff;
  localparam logic [DW-1:0] OFF_CAL  = 14'h2000;
  localparam int POR_TIME_NS = 10000000;
  localparam int CLK_NS      = 8;
  localparam int POR_CYCLES  = POR_TIME_NS / CLK_NS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef logic [NCH-1:0][DW-1:0] code_arr_t;

  typedef struct packed {
    logic [DW-1:0]  ctrl;
    logic [5:0]     mon_sel;
    code_arr_t      a;
    code_arr_t      b;
    code_arr_t      off;
    code_arr_t      gain;
    code_arr_t      dac;
    logic [NCH-1:0] dirty;
    logic [NCH-1:0] sel_b;
    logic [1:0]     tog_prev;
    logic           shut;
    logic           busy;
    logic [20:0]    por_cnt;
    logic [1:0]     ld_sync;
    logic [1:0]     ot_sync;
    logic [1:0]     var_sync;
    logic           ld_prev;
    logic [31:0]    rdata;
    logic           err;
  } st_t;

  localparam st_t ST_RST = '{busy: 1'b1, ld_sync: 2'h3, ld_prev: 1'b1, default: '0};

endpackage : dac_ctl_pkg

//--- core/dac_cal_corr.sv
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------------
// Per-channel gain and offset correction
// ------------------------------------------------------------------
module dac_cal_corr (
  input  wire logic [13:0] data_in,
  input  wire logic [13:0] gain_in,
  input  wire logic [13:0] offset_in,
  output logic      [13:0] code_out
);

  logic [28:0] prod;
  logic [17:0] sum;
  logic [17:0] mid;

  // Scale by (gain+1)/2^14, add offset around mid, then clamp
  always_comb begin
    mid  = 18'(dac_ctl_pkg::OFF_CAL);
    prod = 29'(data_in) * 29'({1'b0, gain_in} + 15'h0001);
    sum  = 18'(prod[28:14]) + 18'(offset_in);
    if (sum < mid) begin
      code_out = 14'h0000;          // Negative result pins at zero
    end else if ((sum - mid) > 18'h03fff) begin
      code_out = 14'h3fff;
    end else begin
      code_out = 14'(sum - mid);
    end
  end

endmodule : dac_cal_corr

`default_nettype wire

//--- dv/strobe_host.sv
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------------
// Host side of the load strobe
// ------------------------------------------------------------------
module strobe_host (
  input  wire logic clk_in,
  output logic      ld_n_out
);
  initial ld_n_out = 1'b1;

  // Low for a given count, then idle; the pulse rate sets the wave rate
  task automatic pulse(input int low_cycles);
    ld_n_out <= 1'b0;
    repeat (low_cycles) @(posedge clk_in);
    ld_n_out <= 1'b1;
    // Sync and update latency must pass before the next pulse
    repeat (8) @(posedge clk_in);
  endtask : pulse
endmodule : strobe_host

`default_nettype wire

//--- dv/testbench.sv
`timescale 1ns/10ps
`default_nettype none

module testbench;
  localparam logic W = 1'b1;
  localparam logic R = 1'b0;
  localparam logic OK = 1'b0;
  localparam logic ER = 1'b1;
  localparam logic [7:0] CT = dac_ctl_pkg::ADDR_CTRL;
  localparam logic [7:0] CM = dac_ctl_pkg::ADDR_CMD;
  localparam logic [7:0] MO = dac_ctl_pkg::ADDR_MON;
  localparam logic [7:0] AC = dac_ctl_pkg::ADDR_ACT;
  localparam logic [7:0] ST = dac_ctl_pkg::ADDR_STAT;

  logic                   clk = 1'b0;
  logic                   rst_b = 1'b0;
  logic                   psel = 1'b0;
  logic                   pen = 1'b0;
  logic                   pwr = 1'b0;
  logic [7:0]             paddr = 8'h00;
  logic [31:0]            pwdata = 32'h0;
  logic                   ot = 1'b0;
  logic                   v12 = 1'b0;
  logic [31:0]            prdata;
  logic                   pready, perr, ld_n, rint, rhi, amp, shut, oe, busy;
  logic [5:0]             route;
  dac_ctl_pkg::code_arr_t dac;
  logic [33:0]            notes[$];
  logic [33:0]            nt;
  logic [13:0]            a3, b3;
  logic [5:0]             sels[4] = '{6'h05, 6'h10, 6'h11, 6'h3f};
  int                     n_mismatch = 0;
  int                     comparisons = 0;
  int                     rnd;

  always #4 clk = ~clk;

  dac_ctl_top #(.POR_CYCLES(20)) dac_ctl_top_i (.CLOCK_IN(clk), .RST_B_IN(rst_b),
    .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(perr),
    .LOAD_STROBE_N_IN(ld_n), .OVERTEMP_IN(ot), .VARIANT_12B_IN(v12), .DAC_CODE_OUT(dac),
    .REF_INTERNAL_OUT(rint), .REF_LEVEL_HI_OUT(rhi), .AMP_POWER_EN_OUT(amp),
    .THERMAL_SHUTDOWN_OUT(shut), .MON_ROUTE_OUT(route), .MON_OE_OUT(oe), .BUSY_OUT(busy));

  strobe_host strobe_host_i (.clk_in(clk), .ld_n_out(ld_n));

  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize

  task automatic cmp(input logic [32:0] got, input logic [32:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp

  task automatic hang();
    n_mismatch++;
    $display("wrong value at %0t: wait ran out", $time);
    summarize();
  endtask : hang

  // Note first, then setup, then access held until pready
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic err);
    int n;
    n = 0;
    notes.push_back({~wr, err, wr ? 32'h0 : d});
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= wr ? d : 32'h0;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    psel <= 1'b0;
    pen <= 1'b0;
    if (pready !== 1'b1) hang();
    @(posedge clk);
  endtask : xfer

  function automatic logic [31:0] cmdw(input logic [1:0] rs, input logic bs,
                                       input logic [5:0] ch, input logic [13:0] d);
    return {7'h0, bs, rs, ch, 2'h0, d};
  endfunction : cmdw

  task automatic wait_idle();
    for (int n = 0; n < 100 && busy !== 1'b0; n++) @(posedge clk);
    if (busy !== 1'b0) hang();
  endtask : wait_idle

  // Strobe, then channel 3 by readback and channel 12 at the port
  task automatic ld_chk(input logic [13:0] e3);
    strobe_host_i.pulse(2);
    xfer(R, 8'h4c, {18'h0, e3}, OK);
    cmp(dac[12], 14'h0090, "channel 12 code");
  endtask : ld_chk

  // Each finished transfer against the oldest note
  always @(posedge clk) begin
    if (psel && pen && pready) begin
      if (notes.size() == 0) begin
        hang();
      end else begin
        nt = notes.pop_front();
        cmp({perr, nt[33] ? prdata : 32'h0}, nt[32:0], "bus transfer");
      end
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rnd = $urandom(32'h78d2);
    a3 = 14'($urandom);
    b3 = 14'($urandom);
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    xfer(W, CT, 32'h4, ER);
    wait_idle();
    xfer(R, ST, 32'h2, OK);
    xfer(R, CT, 32'h0, OK);
    xfer(R, 8'h30, 32'h0, ER);
    $display("test reset finished");
    xfer(W, CM, cmdw(2'h0, 1'b0, 6'h0c, 14'h1400), OK);
    xfer(R, CT, 32'h1400, OK);
    cmp({rint, rhi}, 2'h3, "wide reference");
    xfer(W, CT, 32'h400, OK);
    cmp({rint, rhi}, 2'h2, "wide internal only");
    v12 <= 1'b1;
    ot <= 1'b1;
    xfer(W, CT, 32'h100, OK);
    cmp({rint, rhi}, 2'h2, "narrow reference");
    xfer(R, ST, 32'h1a, OK);
    xfer(W, CT, 32'h140, OK);
    repeat (4) @(posedge clk);
    xfer(R, ST, 32'h19, OK);
    xfer(W, CT, 32'h0, OK);
    xfer(R, ST, 32'h12, OK);
    v12 <= 1'b0;
    xfer(W, CT, 32'h100, OK);
    repeat (4) @(posedge clk);
    cmp({shut, amp}, 2'h2, "hot shutdown");
    xfer(W, AC, 32'h1, OK);
    xfer(R, ST, 32'h1, OK);
    ot <= 1'b0;
    repeat (4) @(posedge clk);
    xfer(R, ST, 32'h1, OK);
    xfer(W, AC, 32'h1, OK);
    xfer(R, ST, 32'h2, OK);
    $display("test reference and thermal finished");
    xfer(W, CT, 32'h0, OK);
    xfer(W, MO, 32'h5, OK);
    cmp(oe, 1'b0, "monitor off");
    xfer(W, CT, 32'h800, OK);
    foreach (sels[i]) begin
      xfer(W, MO, {26'h0, sels[i]}, OK);
      xfer(R, MO, {26'h0, sels[i]}, OK);
      cmp({oe, route}, {sels[i] != 6'h3f, sels[i]}, "monitor");
    end
    $display("test monitor finished");
    xfer(W, CM, cmdw(2'h1, 1'b0, 6'h0c, 14'h1fff), OK);
    xfer(W, CM, cmdw(2'h3, 1'b1, 6'h03, b3), OK);
    xfer(W, CM, cmdw(2'h2, 1'b0, 6'h0c, 14'h2010), OK);
    xfer(W, CM, cmdw(2'h3, 1'b0, 6'h0c, 14'h0100), OK);
    xfer(W, CT, 32'h4, OK);
    xfer(W, CM, cmdw(2'h3, 1'b0, 6'h03, a3), OK);
    ld_chk(a3);
    xfer(W, CM, cmdw(2'h2, 1'b0, 6'h0c, 14'h2020), OK);
    ld_chk(14'h0);
    xfer(W, CM, cmdw(2'h3, 1'b1, 6'h03, b3), OK);
    ld_chk(a3);
    ld_chk(b3);
    ld_chk(a3);
    xfer(W, CT, 32'h0, OK);
    xfer(W, CT, 32'h4, OK);
    ld_chk(a3);
    ld_chk(b3);
    xfer(W, CT, 32'h0, OK);
    ld_chk(a3);
    $display("test toggle finished");
    xfer(W, AC, 32'h2, OK);
    xfer(W, CT, 32'h4, ER);
    wait_idle();
    xfer(R, CT, 32'h0, OK);
    $display("test soft reset finished");
    summarize();
  end
endmodule : testbench

`default_nettype wire
